// file: hw/tlbi_divider.sv
`timescale 1ns/1ps
`default_nettype none

// Free-running restoring divider, one quotient bit per clock
module tlbi_divider
    import tlbi_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [15:0] dividend,
    input wire logic [15:0] divisor,
    output logic [15:0] quotient
);

    logic [4:0] cnt_reg; // Bits left in current pass
    logic [15:0] work_reg; // Dividend shifting out, quotient shifting in
    logic [15:0] rem_reg; // Partial remainder
    logic [15:0] div_reg; // Divisor held for the pass
    logic [16:0] trial; // Remainder with next dividend bit
    logic fits; // Divisor fits into trial
    logic [15:0] rem_next;

    // Trial subtraction
    always_comb begin
        trial = {rem_reg, work_reg[15]};
        fits = (trial >= {1'b0, div_reg});
        rem_next = fits ? 16'(trial - {1'b0, div_reg}) : trial[15:0];
    end

    // Iteration; inputs are resampled every 17 cycles, so the result lags by up to 33
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_reg <= 5'h00;
            work_reg <= 16'h0000;
            rem_reg <= 16'h0000;
            div_reg <= 16'h0001;
            quotient <= 16'h0000;
        end else if (cnt_reg == 5'h00) begin
            // Load a fresh pass; zero divisor saturates instead of hanging
            work_reg <= dividend;
            rem_reg <= 16'h0000;
            div_reg <= divisor;
            cnt_reg <= 5'h10;
        end else begin
            work_reg <= {work_reg[14:0], fits};
            rem_reg <= rem_next;
            cnt_reg <= cnt_reg - 5'h01;
            if (cnt_reg == 5'h01) begin
                quotient <= (div_reg == 16'h0000) ? 16'hffff : {work_reg[14:0], fits};
            end
        end
    end

endmodule // tlbi_divider

`default_nettype wire

// file: hw/tlbi_pkg.sv
package tlbi_pkg;

    // Timebase for brake timers and dynamic brake delay
    localparam int CLK_PERIOD_NS = 10;
    localparam int TIMEBASE_MS = 10;
    localparam int TIMEBASE_CYCLES = (TIMEBASE_MS * 1000000) / CLK_PERIOD_NS;

    // Parameter word width and number of stored settings
    localparam int PW = 16;
    localparam int NUM_PARAMS = 10;

    // Parameter indexes on the setting port
    localparam logic [3:0] IDX_FUNC_SEL = 4'h0;
    localparam logic [3:0] IDX_CMD_MODE = 4'h1;
    localparam logic [3:0] IDX_FWD_CAP = 4'h2;
    localparam logic [3:0] IDX_REV_CAP = 4'h3;
    localparam logic [3:0] IDX_FWD_EXT = 4'h4;
    localparam logic [3:0] IDX_REV_EXT = 4'h5;
    localparam logic [3:0] IDX_TORQUE_GAIN = 4'h6;
    localparam logic [3:0] IDX_BRAKE_DELAY = 4'h7;
    localparam logic [3:0] IDX_BRAKE_SPEED = 4'h8;
    localparam logic [3:0] IDX_BRAKE_WAIT = 4'h9;
    localparam logic [3:0] IDX_STATUS = 4'ha;

    // Setting bit positions
    localparam int CMD_EXT_LIMIT_BIT = 2;
    localparam int CMD_ANALOG_LIMIT_BIT = 15;
    localparam int FUNC_FEEDFWD_BIT = 15;

    // Maximum torque in percent of rated; plain default
    localparam logic [15:0] MAX_TORQUE_PCT = 16'h012c;

    // Reset values
    localparam logic [15:0] RST_FUNC_SEL = 16'h0000;
    localparam logic [15:0] RST_CMD_MODE = 16'h0000;
    localparam logic [15:0] RST_FWD_CAP = MAX_TORQUE_PCT;
    localparam logic [15:0] RST_REV_CAP = MAX_TORQUE_PCT;
    localparam logic [15:0] RST_FWD_EXT = 16'h0064;
    localparam logic [15:0] RST_REV_EXT = 16'h0064;
    localparam logic [15:0] RST_TORQUE_GAIN = 16'h001e;
    localparam logic [15:0] RST_BRAKE_DELAY = 16'h0000;
    localparam logic [15:0] RST_BRAKE_SPEED = 16'h0064;
    localparam logic [15:0] RST_BRAKE_WAIT = 16'h0032;

    // Reset table indexed by parameter index
    localparam logic [NUM_PARAMS*16-1:0] RST_TABLE = {
        RST_BRAKE_WAIT, RST_BRAKE_SPEED, RST_BRAKE_DELAY, RST_TORQUE_GAIN, RST_REV_EXT,
        RST_FWD_EXT, RST_REV_CAP, RST_FWD_CAP, RST_CMD_MODE, RST_FUNC_SEL};

    // Control modes
    typedef enum logic [1:0] {
        MODE_SPEED = 2'h0,
        MODE_INTERNAL_SPEED = 2'h1,
        MODE_TORQUE = 2'h2
    } tlbi_mode_t;

    // Brake sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_OFF = 4'h1,
        ST_ON = 4'h2,
        ST_BRAKE_DELAY = 4'h4,
        ST_COAST = 4'h8
    } tlbi_state_t;

endpackage

// file: hw/tlbi_torque_brake.sv
`timescale 1ns/1ps
`default_nettype none

module tlbi_torque_brake
    import tlbi_pkg::*;
#(
    parameter int TIMEBASE_CYC = TIMEBASE_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic param_wr,
    input wire logic [3:0] param_idx,
    input wire logic [15:0] param_wdata,
    output logic [15:0] param_rdata,
    input wire logic [1:0] control_mode,
    input wire logic servo_on_req,
    input wire logic alarm,
    input wire logic fwd_limit_input,
    input wire logic rev_limit_input,
    input wire logic signed [15:0] analog_torque_input,
    input wire logic signed [15:0] torque_request,
    input wire logic [15:0] motor_speed,
    output logic signed [15:0] torque_out,
    output logic fwd_limit_active,
    output logic rev_limit_active,
    output logic motor_power_on,
    output logic brake_interlock_out,
    output logic dyn_brake_on
);

    // Setting storage
    logic [15:0] param_reg [NUM_PARAMS];

    // Named views of the settings
    logic [15:0] func_sel;
    logic [15:0] cmd_mode;
    logic [15:0] brake_delay;
    logic [15:0] brake_speed;
    logic [15:0] brake_wait;
    assign func_sel = param_reg[IDX_FUNC_SEL];
    assign cmd_mode = param_reg[IDX_CMD_MODE];
    assign brake_delay = param_reg[IDX_BRAKE_DELAY];
    assign brake_speed = param_reg[IDX_BRAKE_SPEED];
    assign brake_wait = param_reg[IDX_BRAKE_WAIT];

    // One register per setting, written through the setting port
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PARAMS; gi++) begin : g_param
            always_ff @(posedge clk) begin
                if (reset) begin
                    param_reg[gi] <= RST_TABLE[gi*16 +: 16];
                end else if (param_wr && param_idx == 4'(gi)) begin
                    param_reg[gi] <= param_wdata;
                end
            end
        end
    endgenerate

    // Analog path
    logic [15:0] analog_mag; // Absolute input voltage in mV
    logic [15:0] analog_pct; // Scaled magnitude in percent of rated
    logic analog_neg_reg; // Sign sampled with the magnitude
    logic analog_neg_d_reg; // Sign delayed towards the quotient

    // Magnitude only, sign handled apart
    assign analog_mag = analog_torque_input[15] ? 16'(~analog_torque_input + 16'sh0001)
                                                : analog_torque_input;

    // Gain is 0.1 V per rated torque: percent = mV / gain
    tlbi_divider u_div (
        .clk(clk),
        .reset(reset),
        .dividend(analog_mag),
        .divisor(param_reg[IDX_TORQUE_GAIN]),
        .quotient(analog_pct)
    );

    // Sign follows the divider loosely; fine for slowly moving inputs
    always_ff @(posedge clk) begin
        if (reset) begin
            analog_neg_reg <= 1'b0;
            analog_neg_d_reg <= 1'b0;
        end else begin
            analog_neg_reg <= analog_torque_input[15];
            analog_neg_d_reg <= analog_neg_reg;
        end
    end

    // Mode qualifiers
    logic internal_mode;
    logic speed_mode;
    logic ext_enable;
    logic analog_limit_en;
    logic feedfwd_en;
    always_comb begin
        internal_mode = (control_mode == MODE_INTERNAL_SPEED);
        speed_mode = (control_mode == MODE_SPEED);
        ext_enable = !cmd_mode[CMD_EXT_LIMIT_BIT] && !internal_mode;
        feedfwd_en = func_sel[FUNC_FEEDFWD_BIT];
        analog_limit_en = cmd_mode[CMD_ANALOG_LIMIT_BIT] && !feedfwd_en && !internal_mode;
    end

    // Limit selection: start from fixed caps, take the smallest active source
    logic [15:0] fwd_lim;
    logic [15:0] rev_lim;
    always_comb begin
        fwd_lim = param_reg[IDX_FWD_CAP];
        rev_lim = param_reg[IDX_REV_CAP];
        if (ext_enable && fwd_limit_input && param_reg[IDX_FWD_EXT] < fwd_lim) begin
            fwd_lim = param_reg[IDX_FWD_EXT];
        end
        if (ext_enable && rev_limit_input && param_reg[IDX_REV_EXT] < rev_lim) begin
            rev_lim = param_reg[IDX_REV_EXT];
        end
        if (analog_limit_en && analog_pct < fwd_lim) begin
            fwd_lim = analog_pct;
        end
        if (analog_limit_en && analog_pct < rev_lim) begin
            rev_lim = analog_pct;
        end
        // Keep limits inside the signed output range
        if (fwd_lim[15]) begin
            fwd_lim = 16'h7fff;
        end
        if (rev_lim[15]) begin
            rev_lim = 16'h7fff;
        end
    end

    // Feed-forward term, positive voltage pushes forward
    logic signed [17:0] ff_term;
    logic signed [17:0] torque_sum;
    always_comb begin
        ff_term = 18'sh00000;
        if (feedfwd_en && speed_mode) begin
            ff_term = analog_neg_d_reg ? -$signed({2'b00, analog_pct}) : $signed({2'b00, analog_pct});
        end
        torque_sum = 18'(torque_request) + ff_term;
    end

    // Clamp to the selected limits and register the result
    always_ff @(posedge clk) begin
        if (reset) begin
            torque_out <= 16'sh0000;
            fwd_limit_active <= 1'b0;
            rev_limit_active <= 1'b0;
        end else if (!motor_power_on) begin
            // No torque without motor power
            torque_out <= 16'sh0000;
            fwd_limit_active <= 1'b0;
            rev_limit_active <= 1'b0;
        end else if (torque_sum > $signed({2'b00, fwd_lim})) begin
            torque_out <= $signed(fwd_lim);
            fwd_limit_active <= 1'b1;
            rev_limit_active <= 1'b0;
        end else if (torque_sum < -$signed({2'b00, rev_lim})) begin
            torque_out <= -$signed(rev_lim);
            fwd_limit_active <= 1'b0;
            rev_limit_active <= 1'b1;
        end else begin
            torque_out <= torque_sum[15:0];
            fwd_limit_active <= 1'b0;
            rev_limit_active <= 1'b0;
        end
    end

    // Brake sequencer
    tlbi_state_t state_reg;
    tlbi_state_t state_next;
    logic below_speed; // Motor counted as stopped
    logic [23:0] presc_reg; // Cycles within the current 10 ms tick
    logic [15:0] tick_cnt_reg; // Whole 10 ms ticks since the servo-off event
    logic tick;
    logic timer_restart; // Entry into a timed state
    logic [23:0] db_cnt_reg; // Cycles since motor power went off
    logic power_next; // Power decision taken at the coming edge

    assign below_speed = (motor_speed < brake_speed);
    assign tick = (presc_reg == 24'(TIMEBASE_CYC - 1));
    assign power_next = (state_next == ST_ON) || (state_next == ST_BRAKE_DELAY);

    // Next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF: begin
                // Power and brake release together
                if (servo_on_req && !alarm) begin
                    state_next = ST_ON;
                end
            end
            ST_ON: begin
                if (alarm || !servo_on_req) begin
                    if (below_speed) begin
                        // Stopped: brake first, then drop power after a delay; on alarm both drop at once
                        state_next = alarm ? ST_OFF : ST_BRAKE_DELAY;
                    end else begin
                        // Rotating: power off now, brake later
                        state_next = ST_COAST;
                    end
                end
            end
            ST_BRAKE_DELAY: begin
                if (alarm || tick_cnt_reg >= brake_delay) begin
                    state_next = ST_OFF;
                end
            end
            ST_COAST: begin
                // Whichever comes first
                if (below_speed || tick_cnt_reg >= brake_wait) begin
                    state_next = ST_OFF;
                end
            end
            default: begin
                state_next = ST_OFF;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= ST_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    assign timer_restart = (state_next != state_reg) &&
                           (state_next == ST_BRAKE_DELAY || state_next == ST_COAST);

    // 10 ms prescaler; restarting keeps delays from running short
    always_ff @(posedge clk) begin
        if (reset || timer_restart || tick) begin
            presc_reg <= 24'h000000;
        end else begin
            presc_reg <= presc_reg + 24'h000001;
        end
    end

    // Tick counter, saturating so a stuck state cannot wrap back
    always_ff @(posedge clk) begin
        if (reset || timer_restart) begin
            tick_cnt_reg <= 16'h0000;
        end else if (tick && tick_cnt_reg != 16'hffff) begin
            tick_cnt_reg <= tick_cnt_reg + 16'h0001;
        end
    end

    // Power and brake outputs
    always_ff @(posedge clk) begin
        if (reset) begin
            motor_power_on <= 1'b0;
            brake_interlock_out <= 1'b0;
        end else begin
            motor_power_on <= power_next;
            brake_interlock_out <= (state_next == ST_ON) || (state_next == ST_COAST);
        end
    end

    // Dynamic brake, one timebase after power removal; motor coasts meanwhile
    // Follows the power decision, so it lets go in the very cycle power returns
    always_ff @(posedge clk) begin
        if (reset) begin
            db_cnt_reg <= 24'(TIMEBASE_CYC); // Already counted out: brake stays held after reset
            dyn_brake_on <= 1'b1;
        end else if (power_next) begin
            db_cnt_reg <= 24'h000000;
            dyn_brake_on <= 1'b0;
        end else if (db_cnt_reg < 24'(TIMEBASE_CYC)) begin
            db_cnt_reg <= db_cnt_reg + 24'h000001;
            dyn_brake_on <= 1'b0;
        end else begin
            dyn_brake_on <= 1'b1;
        end
    end

    // Readback: settings plus status word
    always_ff @(posedge clk) begin
        if (reset) begin
            param_rdata <= 16'h0000;
        end else if (param_idx < 4'(NUM_PARAMS)) begin
            param_rdata <= param_reg[param_idx];
        end else if (param_idx == IDX_STATUS) begin
            param_rdata <= {9'h000, dyn_brake_on, brake_interlock_out, motor_power_on, state_reg};
        end else begin
            param_rdata <= 16'h0000;
        end
    end

endmodule // tlbi_torque_brake

`default_nettype wire

// file: tb/tlbi_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

// Motion controller stand-in on the run, limit and analog lines
module tlbi_ctrl_model (
    input wire logic clk,
    input wire logic brake_interlock_out,
    input wire logic [15:0] torque_out,
    output logic servo_on_req,
    output logic fwd_limit_input,
    output logic rev_limit_input,
    output logic signed [15:0] analog_torque_input,
    output logic signed [15:0] torque_request,
    output logic [15:0] motor_speed
);
    // Brake lift allowance, scaled down like the timebase
    parameter int RELEASE_CYC = 8;

    // Idle controller: no run, no limits, no command
    initial begin
        servo_on_req = 1'b0;
        fwd_limit_input = 1'b0;
        rev_limit_input = 1'b0;
        analog_torque_input = 16'sh0000;
        torque_request = 16'sh0000;
        motor_speed = 16'h0000;
    end

    // Run on; hold the command back until the brake has lifted
    task automatic run_on(input logic [15:0] req, output logic ok);
        int n;
        n = 0;
        @(negedge clk);
        servo_on_req = 1'b1;
        while (brake_interlock_out !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        ok = (brake_interlock_out === 1'b1);
        repeat (RELEASE_CYC) @(negedge clk);
        torque_request = req;
    endtask

    // Feed-forward only as a burst of n cycles, torque sampled at its end, then removed
    task automatic ff_burst(input logic [15:0] mv, input int n, output logic [15:0] seen);
        @(negedge clk);
        analog_torque_input = mv;
        repeat (n) @(negedge clk);
        seen = torque_out;
        analog_torque_input = 16'sh0000;
    endtask
endmodule // tlbi_ctrl_model

`default_nettype wire

// file: tb/tlbi_torque_brake_asserts.sv
`timescale 1ns/1ps
`default_nettype none

// Port-level watch on the torque and brake block
module tlbi_torque_brake_asserts
    import tlbi_pkg::*;
#(
    parameter int TIMEBASE_CYC = TIMEBASE_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic param_wr,
    input wire logic [3:0] param_idx,
    input wire logic [15:0] param_wdata,
    input wire logic [15:0] param_rdata,
    input wire logic signed [15:0] torque_out,
    input wire logic fwd_limit_active,
    input wire logic rev_limit_active,
    input wire logic motor_power_on,
    input wire logic brake_interlock_out,
    input wire logic dyn_brake_on
);
    localparam int SAT = TIMEBASE_CYC + 4; // Counter ceiling
    localparam int BRK_MAX = 100 * TIMEBASE_CYC + 4; // Longest legal wait
    int off_cnt; // Cycles since power fell; saturates so reset looks long off
    int brk_cnt; // Cycles with brake open and power off

    // Coast timer
    always_ff @(posedge clk) begin
        if (reset) begin
            off_cnt <= SAT;
        end else if (motor_power_on) begin
            off_cnt <= 0;
        end else if (off_cnt < SAT) begin
            off_cnt <= off_cnt + 1;
        end
    end

    // Brake wait timer
    always_ff @(posedge clk) begin
        if (reset || motor_power_on || !brake_interlock_out) begin
            brk_cnt <= 0;
        end else begin
            brk_cnt <= brk_cnt + 1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_write_read_back: assert property (param_wr && param_idx < 4'ha ##1 !param_wr && $stable(param_idx)
        |=> param_rdata == $past(param_wdata, 2)) else $error("Setting readback mismatch");
    a_cap_max_mag: assert property ($signed(torque_out) <= $signed(MAX_TORQUE_PCT)
        && $signed(torque_out) >= -$signed(MAX_TORQUE_PCT)) else $error("Torque beyond maximum");
    a_fwd_flag_sign: assert property (fwd_limit_active |-> !torque_out[15])
        else $error("Forward clamp with reverse torque");
    a_rev_flag_sign: assert property (rev_limit_active |-> torque_out[15] || torque_out == 16'sh0000)
        else $error("Reverse clamp with forward torque");
    a_unpowered_zero: assert property (!motor_power_on && $past(!motor_power_on) |-> torque_out == 16'sh0000)
        else $error("Torque while unpowered");
    a_release_with_power: assert property ($rose(brake_interlock_out) |-> $rose(motor_power_on))
        else $error("Brake released without power");
    a_dyn_clear_run: assert property ($rose(motor_power_on) |-> !dyn_brake_on)
        else $error("Dynamic brake on while powered");
    a_dyn_coast_gap: assert property (!motor_power_on && off_cnt < TIMEBASE_CYC - 2 |-> !dyn_brake_on)
        else $error("Dynamic brake too early");
    a_dyn_engage_time: assert property (!motor_power_on && off_cnt > TIMEBASE_CYC + 1 |-> dyn_brake_on)
        else $error("Dynamic brake too late");
    a_brake_wait_cap: assert property (brk_cnt <= BRK_MAX)
        else $error("Brake held open too long");

    c_power_up: cover property ($rose(motor_power_on));
    c_brake_coast: cover property ($fell(brake_interlock_out) && !motor_power_on);
    c_fwd_clamp: cover property (fwd_limit_active);
    c_rev_clamp: cover property (rev_limit_active);
endmodule // tlbi_torque_brake_asserts

bind tlbi_torque_brake tlbi_torque_brake_asserts #(.TIMEBASE_CYC(TIMEBASE_CYC)) u_chk (.clk, .reset,
    .param_wr, .param_idx, .param_wdata, .param_rdata, .torque_out, .fwd_limit_active, .rev_limit_active,
    .motor_power_on, .brake_interlock_out, .dyn_brake_on);

`default_nettype wire

// file: tb/tlbi_torque_brake_tb.sv
`timescale 1ns/1ps
`default_nettype none

// Self-checking bench for torque limits and brake sequencing
module tlbi_torque_brake_tb;
    import tlbi_pkg::*;
    localparam int TB = 20; // Shortened 10 ms timebase
    localparam int LIMIT = 20000; // Run ceiling in cycles
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic param_wr = 1'b0;
    logic [3:0] param_idx = 4'h0;
    logic [15:0] param_wdata = 16'h0000;
    logic [1:0] control_mode = 2'h0;
    logic alarm = 1'b0; // Fault path left idle
    wire logic servo_on_req, fwd_limit_input, rev_limit_input;
    wire logic signed [15:0] analog_torque_input, torque_request;
    wire logic [15:0] motor_speed;
    logic [15:0] param_rdata;
    logic signed [15:0] torque_out;
    logic fwd_limit_active, rev_limit_active, motor_power_on, brake_interlock_out, dyn_brake_on;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    logic ok;
    logic [15:0] v;

    always #5 clk = ~clk;

    tlbi_torque_brake #(.TIMEBASE_CYC(TB)) dut (.clk(clk), .reset(reset), .param_wr(param_wr),
        .param_idx(param_idx), .param_wdata(param_wdata), .param_rdata(param_rdata),
        .control_mode(control_mode), .servo_on_req(servo_on_req), .alarm(alarm),
        .fwd_limit_input(fwd_limit_input), .rev_limit_input(rev_limit_input),
        .analog_torque_input(analog_torque_input), .torque_request(torque_request),
        .motor_speed(motor_speed), .torque_out(torque_out), .fwd_limit_active(fwd_limit_active),
        .rev_limit_active(rev_limit_active), .motor_power_on(motor_power_on),
        .brake_interlock_out(brake_interlock_out), .dyn_brake_on(dyn_brake_on));

    tlbi_ctrl_model ctl (.clk(clk), .brake_interlock_out(brake_interlock_out), .torque_out(torque_out),
        .servo_on_req(servo_on_req), .fwd_limit_input(fwd_limit_input), .rev_limit_input(rev_limit_input),
        .analog_torque_input(analog_torque_input), .torque_request(torque_request), .motor_speed(motor_speed));

    // Verdict and end of run
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            error_cnt++;
            conclude();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            error_cnt++;
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [3:0] i, input logic [15:0] d);
        @(negedge clk);
        param_wr = 1'b1;
        param_idx = i;
        param_wdata = d;
        @(negedge clk);
        param_wr = 1'b0;
    endtask

    // Mode and request, settle, compare
    task automatic tq(input logic [1:0] m, input logic [15:0] r, input logic [15:0] e, input int n);
        @(negedge clk);
        control_mode = m;
        ctl.torque_request = r;
        tick(n);
        chk(torque_out, e);
    endtask

    // Defaults after reset, plus an unmapped index
    task automatic t_defaults();
        chk(dyn_brake_on, 1'b1);
        for (int i = 2; i < 10; i++) begin
            param_idx = i[3:0];
            tick(2);
            chk(param_rdata, RST_TABLE[i*16 +: 16]);
        end
        param_idx = 4'hb;
        tick(2);
        chk(param_rdata, 16'h0000);
    endtask

    // Fixed caps in every mode
    task automatic t_caps();
        wr(IDX_FWD_CAP, 16'h0050);
        wr(IDX_REV_CAP, 16'h0040);
        ctl.run_on(16'h0000, ok);
        chk(ok, 1'b1);
        for (int m = 0; m < 3; m++) begin
            tq(m[1:0], 16'h00c8, 16'h0050, 3);
            tq(m[1:0], 16'hff38, 16'hffc0, 3);
        end
        wr(IDX_FWD_CAP, MAX_TORQUE_PCT);
        wr(IDX_REV_CAP, MAX_TORQUE_PCT);
    endtask

    // External limit inputs, enable bit, mode gating, smallest wins
    task automatic t_ext();
        ctl.fwd_limit_input = 1'b1;
        tq(2'h0, 16'h00c8, 16'h0064, 3);
        chk(fwd_limit_active, 1'b1);
        tq(2'h2, 16'h00c8, 16'h0064, 3);
        tq(2'h1, 16'h00c8, 16'h00c8, 3);
        wr(IDX_CMD_MODE, 16'h0004);
        tq(2'h0, 16'h00c8, 16'h00c8, 3);
        wr(IDX_CMD_MODE, 16'h0000);
        wr(IDX_FWD_CAP, 16'h0040);
        tq(2'h0, 16'h00c8, 16'h0040, 3);
        wr(IDX_FWD_CAP, MAX_TORQUE_PCT);
        ctl.fwd_limit_input = 1'b0;
        ctl.rev_limit_input = 1'b1;
        wr(IDX_REV_EXT, 16'h0030);
        tq(2'h0, 16'hff38, 16'hffd0, 3);
        chk(rev_limit_active, 1'b1);
        tq(2'h1, 16'hff38, 16'hff38, 3);
        ctl.rev_limit_input = 1'b0;
    endtask

    // Analog magnitude limit: 1500 mV over gain 30 gives 50 %
    task automatic t_analog();
        ctl.analog_torque_input = 16'sd1500;
        wr(IDX_CMD_MODE, 16'h8000);
        tq(2'h0, 16'h00c8, 16'h0032, 40);
        tq(2'h2, 16'hff38, 16'hffce, 3);
        ctl.analog_torque_input = -16'sd1500;
        tq(2'h0, 16'h00c8, 16'h0032, 40);
        wr(IDX_TORQUE_GAIN, 16'h000a);
        tq(2'h0, 16'h00c8, 16'h0096, 40);
        wr(IDX_TORQUE_GAIN, 16'h001e);
        wr(IDX_FUNC_SEL, 16'h8000);
        tq(2'h2, 16'h00c8, 16'h00c8, 40);
        ctl.analog_torque_input = 16'sh0000;
        wr(IDX_CMD_MODE, 16'h0000);
    endtask

    // Feed-forward: 600 mV over gain 30 adds 20 %
    task automatic t_ff();
        tq(2'h0, 16'h000a, 16'h000a, 40);
        ctl.ff_burst(16'd600, 40, v);
        chk(v, 16'h001e);
        ctl.ff_burst(-16'sd600, 40, v);
        chk(v, 16'hfff6);
        control_mode = 2'h2;
        ctl.ff_burst(16'd600, 40, v);
        chk(v, 16'h000a);
        wr(IDX_FUNC_SEL, 16'h0000);
    endtask

    // Stopped servo-off: brake first, power after two ticks
    task automatic t_stop();
        ctl.torque_request = 16'sh0000;
        ctl.motor_speed = 16'd50;
        wr(IDX_BRAKE_DELAY, 16'h0002);
        ctl.servo_on_req = 1'b0;
        tick(2);
        chk(brake_interlock_out, 1'b0);
        chk(motor_power_on, 1'b1);
        tick(2 * TB - 6);
        chk(motor_power_on, 1'b1);
        tick(10);
        chk(motor_power_on, 1'b0);
        chk(dyn_brake_on, 1'b0);
        param_idx = IDX_STATUS;
        tick(2);
        chk(param_rdata, 16'h0001);
        tick(TB + 4);
        chk(dyn_brake_on, 1'b1);
    endtask

    // Rotating servo-off: speed drop, then wait expiry
    task automatic t_spin();
        wr(IDX_BRAKE_WAIT, 16'h0003);
        for (int k = 0; k < 2; k++) begin
            ctl.run_on(16'h0000, ok);
            ctl.motor_speed = 16'd500;
            tick(1);
            ctl.servo_on_req = 1'b0;
            tick(2);
            chk(motor_power_on, 1'b0);
            chk(brake_interlock_out, 1'b1);
            tick(30 + 20 * k);
            chk(brake_interlock_out, 1'b1);
            if (k == 0) ctl.motor_speed = 16'd50;
            tick(k == 0 ? 3 : 16);
            chk(brake_interlock_out, 1'b0);
        end
    endtask

    // Main sequence
    initial begin
        tick(12);
        reset = 1'b0;
        t_defaults();
        t_caps();
        t_ext();
        t_analog();
        t_ff();
        t_stop();
        t_spin();
        conclude();
    end
endmodule // tlbi_torque_brake_tb

`default_nettype wire
